// ==== core/dacpl_cfg.svh ====
// Timing and coding constants for the parallel-load converter host controller
`ifndef DACPL_CFG_SVH
`define DACPL_CFG_SVH
`define DACPL_CODE_W 12
`define DACPL_MSB_IDX 11
`define DACPL_CLK_NS 20
`define DACPL_CS_MIN_NS 40
`define DACPL_SETUP_NS 20
`define DACPL_HOLD_NS 20
`define DACPL_CS_CYC ((`DACPL_CS_MIN_NS + `DACPL_CLK_NS - 1) / `DACPL_CLK_NS)
`define DACPL_SETUP_CYC ((`DACPL_SETUP_NS + `DACPL_CLK_NS - 1) / `DACPL_CLK_NS)
`define DACPL_HOLD_CYC ((`DACPL_HOLD_NS + `DACPL_CLK_NS - 1) / `DACPL_CLK_NS)
`define DACPL_WAIT_CYC 1
`define DACPL_ZERO_CODE 12'h000
`define DACPL_MID_CODE 12'h800
`define DACPL_FULL_CODE 12'hfff
`endif

// ==== core/dacpl_pkg.sv ====
// Types for the parallel-load converter host controller
`default_nettype none
package dacpl_pkg;
	typedef enum logic [3:0] {
		DACPL_IDLE = 4'h1,
		DACPL_SETUP = 4'h2,
		DACPL_STROBE = 4'h4,
		DACPL_HOLD = 4'h8
	} dacpl_state_t;
	typedef enum logic [1:0] {
		DACPL_UNIPOLAR = 2'h0,
		DACPL_BIPOLAR = 2'h1,
		DACPL_TWOS = 2'h2
	} dacpl_fmt_t;
endpackage : dacpl_pkg
`default_nettype wire

// ==== core/dacpl_phase_cnt.sv ====
// Down counter that times one phase of the write strobe
`default_nettype none
module dacpl_phase_cnt #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	assign cnt_nxt = load ? load_val : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
	// Done looks at the count only, so the sequencer that drives load stays loop-free
	assign done = (cnt_r == '0);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : dacpl_phase_cnt
`default_nettype wire

// ==== core/dacpl_host.sv ====
// Host controller writing 12-bit codes into a parallel-load converter
//
// Functional notes
// RULE1 - Whole 12-bit word written in one cycle
// RULE2 - Converter latches on chip select rising edge
// RULE3 - Data driven positive-true, high means one
// RULE4 - Unipolar codes pass as straight binary
// RULE5 - Bipolar codes are offset binary, 800 zero
// RULE6 - Twos complement input gets MSB inverted
// RULE7 - Unused data lines driven low, never floating
// RULE8 - Select asserted only on writes to address
// RULE9 - Acknowledge formed when strobe meets decode
// RULE10 - Select ends when write pulse ends
// RULE11 - Port number decoded, eight ports selectable
// RULE12 - Decoder enabled by io space select
// RULE13 - Store strobe ORed with memory-select decode; here select comes from the sequencer state alone, io space select only gates take
// RULE14 - Wait state stretches select one cycle
// RULE15 - Wait completes, then acknowledge returns high
// RULE16 - Fast hosts insert one wait state
// RULE17 - Data stable throughout select and edge
`include "dacpl_cfg.svh"
`default_nettype none
module dacpl_host
	import dacpl_pkg::*;
#(
	parameter int CODE_W = `DACPL_CODE_W,
	parameter logic [2:0] MY_PORT = 3'h0,
	parameter int WAIT_CYC = `DACPL_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_valid,
	input wire logic [CODE_W-1:0] wr_value,
	input wire logic [1:0] wr_fmt,
	input wire logic [2:0] wr_port,
	input wire logic io_space_select_b,
	output logic wr_ready,
	output logic wr_done,
	output logic [CODE_W-1:0] dac_code_inputs,
	output logic dac_cs_b,
	output logic transfer_acknowledge_b
);
	// ----------------------------------------
	// Code formatting
	// ----------------------------------------
	localparam int CNT_W = 4;
	dacpl_state_t state_r;
	dacpl_state_t state_nxt;
	logic [CODE_W-1:0] code_r;
	logic [CODE_W-1:0] code_nxt;
	logic cs_b_r;
	logic ack_b_r;
	logic ready_r;
	logic done_r;
	logic [CNT_W-1:0] phase_len;
	logic phase_load;
	logic phase_done;
	wire [CODE_W-1:0] msb_flip = {1'b1, {(CODE_W-1){1'b0}}};
	wire fmt_twos = (wr_fmt == DACPL_TWOS);
	// Unipolar and bipolar codes pass unchanged; twos complement gets MSB inverted
	wire [CODE_W-1:0] fmt_val = fmt_twos ? (wr_value ^ msb_flip) : wr_value; // RULE4 RULE5 RULE6
	// ----------------------------------------
	// Port decode
	// ----------------------------------------
	wire port_hit = (wr_port == MY_PORT) && !io_space_select_b; // RULE11 RULE12
	wire take = ready_r && wr_valid && port_hit; // RULE8
	assign code_nxt = take ? fmt_val : code_r;
	// ----------------------------------------
	// Strobe sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		phase_load = 1'b0;
		phase_len = '0;
		unique case (state_r)
			DACPL_IDLE: begin
				if (take) begin
					state_nxt = DACPL_SETUP;
					phase_load = 1'b1;
					phase_len = CNT_W'(`DACPL_SETUP_CYC - 1);
				end
			end
			DACPL_SETUP: begin
				if (phase_done) begin
					state_nxt = DACPL_STROBE;
					phase_load = 1'b1;
					phase_len = CNT_W'(`DACPL_CS_CYC + WAIT_CYC - 1); // RULE14 RULE16
				end
			end
			DACPL_STROBE: begin
				if (phase_done) begin
					state_nxt = DACPL_HOLD;
					phase_load = 1'b1;
					phase_len = CNT_W'(`DACPL_HOLD_CYC - 1);
				end
			end
			DACPL_HOLD: begin
				if (phase_done) begin
					state_nxt = DACPL_IDLE;
				end
			end
			default: begin
				state_nxt = DACPL_IDLE;
			end
		endcase
	end
	dacpl_phase_cnt #(
		.W(CNT_W)
	) u_phase (
		.clk(clk),
		.rst_b(rst_b),
		.load(phase_load),
		.load_val(phase_len),
		.done(phase_done)
	);
	wire cs_b_nxt = !(state_nxt == DACPL_STROBE); // RULE2 RULE10 RULE13
	wire ack_b_nxt = !(state_r == DACPL_STROBE && state_nxt == DACPL_HOLD); // RULE9 RULE15
	wire ready_nxt = (state_nxt == DACPL_IDLE);
	wire done_nxt = (state_r == DACPL_HOLD) && phase_done;
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= DACPL_IDLE;
			code_r <= '0; // RULE7
			cs_b_r <= 1'b1;
			ack_b_r <= 1'b1;
			ready_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			code_r <= code_nxt; // RULE1 RULE3 RULE17
			cs_b_r <= cs_b_nxt;
			ack_b_r <= ack_b_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a plain register copy
	assign dac_code_inputs = code_r;
	assign dac_cs_b = cs_b_r;
	assign transfer_acknowledge_b = ack_b_r;
	assign wr_ready = ready_r;
	assign wr_done = done_r;
	// ----------------------------------------
	// Protocol sequences
	// ----------------------------------------
	sequence s_cs_fall;
		$fell(dac_cs_b);
	endsequence
	sequence s_cs_low_min;
		!dac_cs_b [*3];
	endsequence
	sequence s_cs_release;
		dac_cs_b;
	endsequence
	sequence s_ack_pulse;
		!transfer_acknowledge_b ##1 transfer_acknowledge_b;
	endsequence
	sequence s_done_pulse;
		wr_done ##1 !wr_done;
	endsequence
	sequence s_idle_outputs;
		dac_cs_b && transfer_acknowledge_b && !wr_ready && !wr_done
			&& (dac_code_inputs == '0);
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_cs_pulse_width: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
		s_cs_fall |-> s_cs_low_min) else $error("chip select shorter than three cycles");
	a_cs_exact_len: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
		s_cs_fall |-> s_cs_low_min ##1 s_cs_release)
		else $error("chip select longer than three cycles");
	a_data_stable_cs: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		!dac_cs_b |-> $stable(dac_code_inputs)) else $error("code changed while selected");
	a_data_hold_edge: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
		$past(rst_b) && $rose(dac_cs_b) |-> $stable(dac_code_inputs))
		else $error("code changed at select rise");
	a_take_setup: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		take |=> dac_cs_b ##1 !dac_cs_b) else $error("code not set up before select");
	a_busy_code_held: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		!wr_ready |=> $stable(dac_code_inputs)) else $error("code changed while busy");
	a_ack_after_cs: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
		$past(rst_b) && $rose(dac_cs_b) |-> $fell(transfer_acknowledge_b))
		else $error("no acknowledge at end");
	a_ack_at_release: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
		$fell(transfer_acknowledge_b) |-> $rose(dac_cs_b)) else $error("stray acknowledge");
	a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
		$fell(transfer_acknowledge_b) |-> s_ack_pulse) else $error("acknowledge not one cycle");
	a_ready_no_select: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
		wr_ready |-> dac_cs_b && transfer_acknowledge_b) else $error("select active while idle");
	a_twos_msb_flip: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
		take && fmt_twos |=> dac_code_inputs[`DACPL_MSB_IDX] == !$past(wr_value[`DACPL_MSB_IDX]))
		else $error("twos complement MSB not inverted");
	a_twos_low_bits: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
		take && (wr_fmt == DACPL_TWOS) |=> dac_code_inputs[CODE_W-2:0] == $past(wr_value[CODE_W-2:0]))
		else $error("twos complement low bits altered");
	a_binary_pass: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
		take && !fmt_twos |=> dac_code_inputs == $past(wr_value)) else $error("binary code altered");
	a_bipolar_pass: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
		take && (wr_fmt == DACPL_BIPOLAR) |=> dac_code_inputs == $past(wr_value))
		else $error("bipolar code altered");
	a_port_select: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
		wr_valid && ready_r && (wr_port != MY_PORT) |=> ready_r)
		else $error("unselected port took write");
	a_io_space_gate: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
		wr_valid && ready_r && io_space_select_b |=> ready_r)
		else $error("write taken outside io space");
	a_done_timing: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		take |-> ##6 wr_done) else $error("write did not finish in six cycles");
	a_done_one_cycle: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		wr_done |-> s_done_pulse) else $error("done longer than one cycle");
	a_done_ready: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		wr_done |-> wr_ready) else $error("done without ready");
	a_reset_outputs: assert property (@(posedge clk) // RULE7
		!rst_b |=> s_idle_outputs) else $error("outputs not idle after reset");
endmodule : dacpl_host
`default_nettype wire

// ==== bench/dacpl_conv_model.sv ====
// Behavioural model of the converter's parallel input register
`default_nettype none
module dacpl_conv_model
	import dacpl_pkg::*;
(
	input wire logic cs_b,
	input wire logic [11:0] code_in,
	output logic [11:0] held
);
	timeunit 1ns;
	timeprecision 1ps;
	// Latch on select release; open lines read as zero
	always @(posedge cs_b) begin
		for (int i = 0; i < 12; i++) begin
			held[i] <= (code_in[i] === 1'b1);
		end
	end
endmodule : dacpl_conv_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the converter host controller
`default_nettype none
module tb_top
	import dacpl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr_valid = 1'b0;
	logic [11:0] wr_value = 12'h000;
	logic [1:0] wr_fmt = 2'h0;
	logic [2:0] wr_port = 3'h0;
	logic io_b = 1'b0;
	logic rdy, done, cs_b, ack_b;
	logic [11:0] code, held;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #10 clk = ~clk;
	dacpl_host uut (.clk(clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr_value(wr_value),
		.wr_fmt(wr_fmt), .wr_port(wr_port), .io_space_select_b(io_b), .wr_ready(rdy),
		.wr_done(done), .dac_code_inputs(code), .dac_cs_b(cs_b),
		.transfer_acknowledge_b(ack_b));
	dacpl_conv_model conv (.cs_b(cs_b), .code_in(code), .held(held));
	task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			stop_test();
		end
	end
	// One full write, timing of select, acknowledge and done
	task wr_one(input logic [11:0] v, input logic [1:0] f, input logic [11:0] exp);
		int lo, ak, dn;
		lo = 0;
		ak = 0;
		dn = 0;
		chk("ready", {11'h0, rdy}, 12'h001);
		wr_valid = 1'b1;
		wr_value = v;
		wr_fmt = f;
		@(posedge clk);
		#1 wr_valid = 1'b0;
		for (int i = 1; i <= 8; i++) begin
			@(posedge clk);
			#1 if (cs_b === 1'b0) lo++;
			if (ack_b === 1'b0) ak = ak * 16 + i;
			if (done === 1'b1) dn = dn * 16 + i;
		end
		chk("code", code, exp);
		chk("latched", held, exp);
		chk("cs low", 12'(lo), 12'h003);
		chk("ack", 12'(ak), 12'h004);
		chk("done", 12'(dn), 12'h005);
	endtask : wr_one
	task t_unipolar;
		wr_one(12'hfff, DACPL_UNIPOLAR, 12'hfff);
		wr_one(12'h000, DACPL_UNIPOLAR, 12'h000);
		wr_one(12'h0a5, 2'h3, 12'h0a5);
		$display("unipolar done");
	endtask : t_unipolar
	task t_bipolar;
		wr_one(12'h800, DACPL_BIPOLAR, 12'h800);
		wr_one(12'hfff, DACPL_BIPOLAR, 12'hfff);
		$display("bipolar done");
	endtask : t_bipolar
	task t_twos;
		wr_one(12'h7ff, DACPL_TWOS, 12'hfff);
		wr_one(12'h800, DACPL_TWOS, 12'h000);
		wr_one(12'h000, DACPL_TWOS, 12'h800);
		$display("twos done");
	endtask : t_twos
	task t_refused;
		int lo;
		lo = 0;
		wr_valid = 1'b1;
		wr_value = 12'h123;
		wr_port = 3'h1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1 if (cs_b === 1'b0) lo++;
			if (i == 7) begin
				wr_port = 3'h0;
				io_b = 1'b1;
			end
		end
		wr_valid = 1'b0;
		io_b = 1'b0;
		chk("refused cs", 12'(lo), 12'h000);
		chk("refused code", held, 12'h800);
		$display("refused done");
	endtask : t_refused
	// Reset in the middle of a write, then a normal write
	task t_reset;
		@(posedge clk);
		#1 wr_valid = 1'b1;
		wr_value = 12'h5a5;
		wr_fmt = DACPL_UNIPOLAR;
		@(posedge clk);
		#1 wr_valid = 1'b0;
		@(posedge clk);
		#1 chk("mid cs", {11'h0, cs_b}, 12'h000);
		rst_b = 1'b0;
		@(posedge clk);
		#1 chk("rst cs", {11'h0, cs_b}, 12'h001);
		chk("rst ack", {11'h0, ack_b}, 12'h001);
		chk("rst ready", {11'h0, rdy}, 12'h000);
		chk("rst done", {11'h0, done}, 12'h000);
		chk("rst code", code, 12'h000);
		rst_b = 1'b1;
		@(posedge clk);
		#1 chk("rel ready", {11'h0, rdy}, 12'h001);
		wr_one(12'h321, DACPL_UNIPOLAR, 12'h321);
		$display("reset done");
	endtask : t_reset
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("reset code", code, 12'h000);
		t_unipolar();
		t_bipolar();
		t_twos();
		t_refused();
		t_reset();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
